// ### pkg/spms_pkg.sv
package spms_pkg;

  localparam int unsigned SPMS_CLK_HZ     = 40_000_000;
  localparam int unsigned SPMS_AW         = 12;

  // Register indices; byte address is four times the index
  localparam logic [9:0]  SPMS_IDX_DIV_LO = 10'h0B8;
  localparam logic [9:0]  SPMS_IDX_DIV_HI = 10'h0B9;
  localparam logic [9:0]  SPMS_IDX_CTL    = 10'h0BA;
  localparam logic [9:0]  SPMS_IDX_STAT   = 10'h0BB;
  localparam logic [9:0]  SPMS_IDX_DATA   = 10'h0BC;

  // Control register fields
  localparam int unsigned SPMS_CTL_IRQ_EN = 7;
  localparam int unsigned SPMS_CTL_EN     = 5;
  localparam int unsigned SPMS_CTL_MASTER = 4;
  localparam int unsigned SPMS_CTL_CLOCK_POLARITY_SELECT   = 3;
  localparam int unsigned SPMS_CTL_CLOCK_PHASE_SELECT   = 2;

  // Status register fields
  localparam int unsigned SPMS_ST_DONE    = 7;
  localparam int unsigned SPMS_ST_WRITE_COLLISION_FLAG    = 5;
  localparam int unsigned SPMS_ST_MODE_FAULT_FLAG    = 4;

  // Values after reset; bits per transfer and last master clock edge index
  localparam logic [15:0] SPMS_DIV_RST    = 16'h0002;
  localparam logic [7:0]  SPMS_CTL_RST    = 8'h04;
  localparam logic [3:0]  SPMS_BITS       = 4'h8;
  localparam logic [3:0]  SPMS_LAST_EDGE  = 4'hF;

  typedef enum logic [1:0] {
    SPMS_IDLE = 2'b01,
    SPMS_XFER = 2'b10
  } spms_state_e;

  typedef enum logic [5:0] {
    SPMS_R_NONE   = 6'b000001,
    SPMS_R_DIV_LO = 6'b000010,
    SPMS_R_DIV_HI = 6'b000100,
    SPMS_R_CTL    = 6'b001000,
    SPMS_R_STAT   = 6'b010000,
    SPMS_R_DATA   = 6'b100000
  } spms_reg_e;

  typedef struct packed {
    logic sck;
    logic ss_n;
    logic mosi;
    logic miso;
  } spms_pins_s;

  typedef struct packed {
    logic sck_o;
    logic sck_oe;
    logic mosi_o;
    logic mosi_oe;
    logic miso_o;
    logic miso_oe;
  } spms_drive_s;

endpackage

// ### hw/spms_core.sv
// Overview of operation
// - Data-in line input as master, output slave
// - Data-out line output master, input slave
// - Unselected slave floats its data-in output
// - Disabled interface floats both data lines
// - Select low while master sets mode fault
// - Phase zero: shift clock gated by select
// - Master drives serial clock, slave receives it
// - Serial clock is half the baud rate
// - Edge roles follow polarity and phase
// - Master clock idles at polarity level
// - Both ends use identical polarity and phase
// - Data presented half period before sampling
// - Byte exchanged both ways, one done flag
// - Write during transfer dropped, collision flagged
// - Done flag set after eight bits shifted
// - Master write starts eight clock transfer
// - Slave fills shift register then buffers it
// - Slave write loads data for master
// - Phase zero slave framed by select
// - Phase one slave starts on first clock
// - Mode fault clears enable and master bits
// - Status read clears mode fault flag
// - Status read clears write collision flag
// - Baud counter reloads after one, pulses
module spms_core
  import spms_pkg::*;
(
  input  wire logic                 clk,
  input  wire logic                 resetn,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [SPMS_AW-1:0]   paddr,
  input  wire logic [31:0]          pwdata,
  input  wire logic [3:0]           pstrb,
  output logic      [31:0]          prdata,
  output logic                      pready,
  output logic                      pslverr,
  input  wire logic                 sck_i,
  output logic                      sck_o,
  output logic                      sck_oe,
  input  wire logic                 mosi_i,
  output logic                      mosi_o,
  output logic                      mosi_oe,
  input  wire logic                 miso_i,
  output logic                      miso_o,
  output logic                      miso_oe,
  input  wire logic                 ss_n_i,
  output logic                      irq
);

  typedef struct packed {
    spms_state_e  st;
    logic         irq_en;
    logic         en;
    logic         master;
    logic         clock_polarity_select;
    logic         clock_phase_select;
    logic [15:0]  div;
    logic [15:0]  brg_cnt;
    logic [7:0]   sh;
    logic [7:0]   rxbuf;
    logic         samp;
    logic [3:0]   nsamp;
    logic [3:0]   edges;
    logic         sck_q;
    logic         done;
    logic         write_collision_flag;
    logic         mode_fault_flag;
    spms_pins_s   sync1;
    spms_pins_s   sync2;
    logic         sck_prev;
    logic         ss_prev;
    logic         pready;
    logic         pslverr;
    logic [31:0]  prdata;
    spms_drive_s  drv;
    logic         irq;
  } spms_core_s;

  spms_core_s r_reg;
  spms_core_s r_next;

  function automatic spms_reg_e spms_decode(input logic [SPMS_AW-1:0] a);
    spms_reg_e sel;
    sel = SPMS_R_NONE;
    if (a[1:0] == 2'b00) begin
      case (a[SPMS_AW-1:2])
        SPMS_IDX_DIV_LO: sel = SPMS_R_DIV_LO;
        SPMS_IDX_DIV_HI: sel = SPMS_R_DIV_HI;
        SPMS_IDX_CTL:    sel = SPMS_R_CTL;
        SPMS_IDX_STAT:   sel = SPMS_R_STAT;
        SPMS_IDX_DATA:   sel = SPMS_R_DATA;
        default:         sel = SPMS_R_NONE;
      endcase
    end
    return sel;
  endfunction

  logic       acc;
  logic       wr;
  logic       rd;
  logic       pulse;
  logic       lead;
  logic       trail;
  logic       go;
  logic       fin;
  logic       ss_low;
  logic       in_bit;
  logic [7:0] rdval;
  spms_reg_e  sel;

  always_comb begin
    r_next = r_reg;
    lead   = 1'b0;
    trail  = 1'b0;
    fin    = 1'b0;
    pulse  = 1'b0;
    rdval  = 8'h00;
    sel    = spms_decode(paddr);
    acc    = psel & penable & r_reg.pready;
    wr     = acc & pwrite;
    rd     = acc & ~pwrite;

    // Pins cross in through two flops; edge logic reads only the second stage
    r_next.sync1    = '{sck: sck_i, ss_n: ss_n_i, mosi: mosi_i, miso: miso_i};
    r_next.sync2    = r_reg.sync1;
    r_next.sck_prev = r_reg.sync2.sck;
    r_next.ss_prev  = r_reg.sync2.ss_n;
    ss_low          = ~r_reg.sync2.ss_n;
    in_bit          = r_reg.master ? r_reg.sync2.miso : r_reg.sync2.mosi;

    // Counting down to one rather than zero keeps a zero divisor from hanging
    if (r_reg.brg_cnt <= 16'h0001) begin
      r_next.brg_cnt = r_reg.div;
      pulse          = 1'b1;
    end else begin
      r_next.brg_cnt = r_reg.brg_cnt - 16'h0001;
    end

    // One wait state: data and pready are registered in the first access cycle
    r_next.pready  = psel & penable & ~r_reg.pready;
    r_next.pslverr = psel & penable & ~r_reg.pready & (sel == SPMS_R_NONE);
    case (sel)
      SPMS_R_DIV_LO: rdval = r_reg.div[7:0];
      SPMS_R_DIV_HI: rdval = r_reg.div[15:8];
      SPMS_R_CTL:    rdval = {r_reg.irq_en, 1'b0, r_reg.en, r_reg.master,
                              r_reg.clock_polarity_select, r_reg.clock_phase_select, 2'b00};
      SPMS_R_STAT:   rdval = {r_reg.done, 1'b0, r_reg.write_collision_flag, r_reg.mode_fault_flag, 4'h0};
      SPMS_R_DATA:   rdval = r_reg.rxbuf;
      default:       rdval = 8'h00;
    endcase
    if (psel && penable && !r_reg.pready) begin
      r_next.prdata = {24'h000000, rdval};
    end

    // Read side effects first, so hardware sets below win over them
    if (rd && sel == SPMS_R_STAT) begin
      r_next.mode_fault_flag = 1'b0;
      r_next.write_collision_flag = 1'b0;
    end
    if (rd && sel == SPMS_R_DATA) begin
      r_next.done = 1'b0;
    end

    if (wr && pstrb[0]) begin
      case (sel)
        SPMS_R_DIV_LO: begin
          r_next.div[7:0] = pwdata[7:0];
          r_next.brg_cnt  = {r_reg.div[15:8], pwdata[7:0]};
        end
        SPMS_R_DIV_HI: begin
          r_next.div[15:8] = pwdata[7:0];
          r_next.brg_cnt   = {pwdata[7:0], r_reg.div[7:0]};
        end
        SPMS_R_CTL: begin
          r_next.irq_en = pwdata[SPMS_CTL_IRQ_EN];
          r_next.en     = pwdata[SPMS_CTL_EN];
          r_next.master = pwdata[SPMS_CTL_MASTER];
          r_next.clock_polarity_select   = pwdata[SPMS_CTL_CLOCK_POLARITY_SELECT];
          r_next.clock_phase_select   = pwdata[SPMS_CTL_CLOCK_PHASE_SELECT];
          if (!pwdata[SPMS_CTL_EN] || pwdata[SPMS_CTL_MASTER] != r_reg.master) begin
            r_next.st    = SPMS_IDLE;
            r_next.nsamp = 4'h0;
            r_next.edges = 4'h0;
          end
        end
        SPMS_R_DATA: begin
          if (r_reg.st == SPMS_XFER) begin
            r_next.write_collision_flag = 1'b1;
          end else begin
            r_next.sh    = pwdata[7:0];
            r_next.nsamp = 4'h0;
            r_next.edges = 4'h0;
            if (r_reg.en && r_reg.master) begin
              r_next.st = SPMS_XFER;
            end
          end
        end
        default: begin
        end
      endcase
    end

    go = (r_reg.st == SPMS_XFER);
    if (r_reg.en && r_reg.master) begin
      if (go && pulse) begin
        // Every baud pulse is one half period of the serial clock
        r_next.sck_q = ~r_reg.sck_q;
        lead         = ~r_reg.edges[0];
        trail        = r_reg.edges[0];
        r_next.edges = r_reg.edges + 4'h1;
      end
      if (ss_low) begin
        r_next.mode_fault_flag   = 1'b1;
        r_next.en     = 1'b0;
        r_next.master = 1'b0;
        r_next.st     = SPMS_IDLE;
        go            = 1'b0;
        lead          = 1'b0;
        trail         = 1'b0;
      end
    end else if (r_reg.en) begin
      // Select high masks every clock edge, as the gated shift clock would
      if (ss_low && r_reg.sync2.sck != r_reg.sck_prev) begin
        lead  = (r_reg.sync2.sck != r_reg.clock_polarity_select);
        trail = ~lead;
      end
      if (!r_reg.clock_phase_select) begin
        if (r_reg.st == SPMS_IDLE && ss_low && r_reg.ss_prev) begin
          r_next.st    = SPMS_XFER;
          r_next.nsamp = 4'h0;
        end
        if (r_reg.st == SPMS_XFER && !ss_low) begin
          r_next.st    = SPMS_IDLE;
          r_next.nsamp = 4'h0;
          go           = 1'b0;
        end
      end else if (r_reg.st == SPMS_IDLE && lead) begin
        r_next.st    = SPMS_XFER;
        r_next.nsamp = 4'h0;
        go           = 1'b1;
      end
    end

    // Shared shift engine for both roles and all four timings
    if (go && lead) begin
      if (!r_reg.clock_phase_select) begin
        r_next.samp  = in_bit;
        r_next.nsamp = r_next.nsamp + 4'h1;
      end else if (r_next.nsamp != 4'h0) begin
        r_next.sh = {r_reg.sh[6:0], r_reg.samp};
      end
    end
    if (go && trail) begin
      if (!r_reg.clock_phase_select) begin
        r_next.sh = {r_reg.sh[6:0], r_reg.samp};
        if (r_reg.nsamp == SPMS_BITS) begin
          fin = 1'b1;
        end
      end else begin
        r_next.samp  = in_bit;
        r_next.nsamp = r_reg.nsamp + 4'h1;
        if (r_reg.nsamp == SPMS_BITS - 4'h1) begin
          r_next.sh = {r_reg.sh[6:0], in_bit};
          fin       = 1'b1;
        end
      end
    end
    if (r_reg.master && r_reg.edges == SPMS_LAST_EDGE && trail && !fin) begin
      fin = 1'b1;
    end

    if (fin) begin
      r_next.rxbuf = r_next.sh;
      r_next.done  = 1'b1;
      r_next.st    = SPMS_IDLE;
      r_next.nsamp = 4'h0;
      r_next.edges = 4'h0;
    end

    if (r_next.st == SPMS_IDLE) begin
      r_next.sck_q = r_next.clock_polarity_select;
    end

    r_next.drv.sck_o   = r_next.sck_q;
    r_next.drv.sck_oe  = r_next.en & r_next.master;
    r_next.drv.mosi_o  = r_next.sh[7];
    r_next.drv.mosi_oe = r_next.en & r_next.master;
    r_next.drv.miso_o  = r_next.sh[7];
    r_next.drv.miso_oe = r_next.en & ~r_next.master & ss_low;
    r_next.irq = r_next.irq_en & (r_next.done | r_next.write_collision_flag | r_next.mode_fault_flag);
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      r_reg          <= '0;
      r_reg.st       <= SPMS_IDLE;
      r_reg.irq_en   <= SPMS_CTL_RST[SPMS_CTL_IRQ_EN];
      r_reg.en       <= SPMS_CTL_RST[SPMS_CTL_EN];
      r_reg.master   <= SPMS_CTL_RST[SPMS_CTL_MASTER];
      r_reg.clock_polarity_select     <= SPMS_CTL_RST[SPMS_CTL_CLOCK_POLARITY_SELECT];
      r_reg.clock_phase_select     <= SPMS_CTL_RST[SPMS_CTL_CLOCK_PHASE_SELECT];
      r_reg.div      <= SPMS_DIV_RST;
      r_reg.brg_cnt  <= SPMS_DIV_RST;
      r_reg.sync1    <= '{sck: 1'b0, ss_n: 1'b1, mosi: 1'b0, miso: 1'b0};
      r_reg.sync2    <= '{sck: 1'b0, ss_n: 1'b1, mosi: 1'b0, miso: 1'b0};
      r_reg.ss_prev  <= 1'b1;
    end else begin
      r_reg <= r_next;
    end
  end

  assign prdata  = r_reg.prdata;
  assign pready  = r_reg.pready;
  assign pslverr = r_reg.pslverr;
  assign sck_o   = r_reg.drv.sck_o;
  assign sck_oe  = r_reg.drv.sck_oe;
  assign mosi_o  = r_reg.drv.mosi_o;
  assign mosi_oe = r_reg.drv.mosi_oe;
  assign miso_o  = r_reg.drv.miso_o;
  assign miso_oe = r_reg.drv.miso_oe;
  assign irq     = r_reg.irq;

endmodule

// ### verification/spms_core_asserts.sv
module spms_core_asserts
  import spms_pkg::*;
(
  input wire logic        clk,
  input wire logic        resetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        sck_o,
  input wire logic        sck_oe,
  input wire logic        mosi_oe,
  input wire logic        miso_oe,
  input wire logic        ss_n_i
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);

  a_one_role: assert property (!(miso_oe && (mosi_oe || sck_oe)))
    else $error("both roles drive");
  a_oe_pair: assert property (mosi_oe == sck_oe)
    else $error("mosi and sck enables differ");
  a_unsel_float: assert property (ss_n_i [*4] |-> !miso_oe)
    else $error("unselected slave drives miso");
  // Select passes two sync flops, so allow a short settle
  a_mode_fault_flag_stop: assert property (sck_oe && !ss_n_i ##1 !ss_n_i [*3] |-> ##[0:3] !sck_oe)
    else $error("master kept driving after fault");
  a_sck_half: assert property (sck_oe && $past(sck_oe) && $changed(sck_o)
    |=> $stable(sck_o) [*2])
    else $error("serial clock half period too short");
  a_rdy_wait: assert property (psel && $rose(penable) |-> !pready ##1 pready)
    else $error("ready not in second access cycle");
  a_rdy_once: assert property (pready |=> !pready)
    else $error("ready held too long");
  a_err_zero: assert property (pready && pslverr |-> prdata == 32'h00000000)
    else $error("refused access returned data");
  a_rd_narrow: assert property (pready && !pwrite |-> prdata[31:8] == 24'h000000)
    else $error("upper read bits not zero");

  c_xfer: cover property (sck_oe && $changed(sck_o));
  c_fault: cover property (sck_oe ##1 !sck_oe);
  c_refuse: cover property (pready && pslverr);
endmodule

bind spms_core spms_core_asserts i_spms_core_asserts (.clk, .resetn, .psel, .penable,
  .pwrite, .prdata, .pready, .pslverr, .sck_o, .sck_oe, .mosi_oe, .miso_oe, .ss_n_i);

// ### verification/spms_slave_model.sv
module spms_slave_model (
  input  wire logic       sck,
  input  wire logic       sel_n,
  input  wire logic       mosi,
  input  wire logic       clock_polarity_select,
  input  wire logic       clock_phase_select,
  input  wire logic [7:0] tx,
  output logic            miso,
  output logic [7:0]      rx
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] sh = 8'h00;
  int         n;
  // Released line shows the inverse so a stale bit cannot pass
  assign miso = sel_n ? ~sh[7] : sh[7];
  always @(negedge sel_n) begin
    sh = tx;
    n = 0;
  end
  always @(sck) begin
    if (!sel_n && sck == (clock_polarity_select == clock_phase_select)) begin
      rx = {rx[6:0], mosi};
      n++;
    end else if (!sel_n && n > 0) begin
      sh = {sh[6:0], ~sh[0]};
    end
  end
endmodule

// ### verification/spms_core_tb_top.sv
module spms_core_tb_top
  import spms_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, resetn, psel, penable, pwrite, pready, pslverr, irq, e;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic        sck_o, sck_oe, mosi_o, mosi_oe, miso_o, miso_oe, ss_n, slv_n;
  logic        sck_w, mosi_w, miso_w, p_miso, clock_polarity_select, clock_phase_select, m_sck, m_mosi;
  logic [7:0]  sv_tx, sv_rx, sl_rx;
  int          err_total, n_compared, cyc;

  spms_core i_spms_core (.clk, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pstrb(4'hF), .prdata, .pready, .pslverr, .sck_i(sck_w), .sck_o, .sck_oe,
    .mosi_i(mosi_w), .mosi_o, .mosi_oe, .miso_i(miso_w), .miso_o, .miso_oe,
    .ss_n_i(ss_n), .irq);
  spms_slave_model i_spms_slave_model (.sck(sck_w), .sel_n(slv_n), .mosi(mosi_w),
    .clock_polarity_select, .clock_phase_select, .tx(sv_tx), .miso(p_miso), .rx(sv_rx));

  assign sck_w  = sck_oe ? sck_o : m_sck;
  assign mosi_w = mosi_oe ? mosi_o : m_mosi;
  assign miso_w = miso_oe ? miso_o : p_miso;

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic chk(input logic [7:0] g, input logic [7:0] x);
    n_compared++;
    if (g !== x) begin
      err_total++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask

  // One idle edge after each transfer keeps every strobe single-driven
  task automatic apb(input logic w, input logic [9:0] idx, input logic [7:0] d);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= {idx, 2'b00};
    pwdata  <= {24'h000000, d};
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wr(input logic [9:0] idx, input logic [7:0] d);
    apb(1'b1, idx, d);
  endtask

  task automatic rd(input logic [9:0] idx, input logic [7:0] x);
    apb(1'b0, idx, 8'h00);
    chk(q[7:0], x);
  endtask

  // External master for slave tests; eight clocks per half period outlast the pin sync delay
  task automatic xfer(input logic [7:0] d);
    for (int b = 7; b >= 0; b--) begin
      if (!clock_phase_select) m_mosi <= d[b];
      repeat (8) @(posedge clk);
      if (!clock_phase_select) sl_rx = {sl_rx[6:0], miso_w};
      m_sck <= ~clock_polarity_select;
      if (clock_phase_select) m_mosi <= d[b];
      repeat (8) @(posedge clk);
      if (clock_phase_select) sl_rx = {sl_rx[6:0], miso_w};
      m_sck <= clock_polarity_select;
    end
    repeat (8) @(posedge clk);
  endtask

  task automatic results();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      results();
    end
  end

  initial begin
    resetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 12'h000; pwdata = 32'h00000000; ss_n = 1'b1; slv_n = 1'b1;
    clock_polarity_select = 1'b0; clock_phase_select = 1'b1; sv_tx = 8'h00; m_sck = 1'b0; m_mosi = 1'b0;
    repeat (3) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    rd(SPMS_IDX_DIV_LO, 8'h02);
    rd(SPMS_IDX_DIV_HI, 8'h00);
    rd(SPMS_IDX_CTL, 8'h04);
    rd(SPMS_IDX_STAT, 8'h00);
    apb(1'b0, 10'h0BD, 8'h00);
    chk(8'(e), 8'h01);
    $display("test reset done");
    wr(SPMS_IDX_DIV_HI, 8'h00);
    wr(SPMS_IDX_DIV_LO, 8'h03);
    for (int m = 0; m < 4; m++) begin
      clock_polarity_select  <= m[1];
      clock_phase_select  <= m[0];
      wr(SPMS_IDX_CTL, 8'(m) << 2);
      wr(SPMS_IDX_CTL, 8'hB0 | (8'(m) << 2));
      sv_tx <= 8'hA5 ^ 8'(m);
      slv_n <= 1'b0;
      wr(SPMS_IDX_DATA, 8'h3C + 8'(m));
      wr(SPMS_IDX_DATA, 8'hFF);
      chk(8'(irq), 8'h01);
      rd(SPMS_IDX_STAT, 8'h20);
      q = 32'h00000000;
      while (q[7] !== 1'b1) apb(1'b0, SPMS_IDX_STAT, 8'h00);
      chk(q[7:0], 8'h80);
      chk(8'(irq), 8'h01);
      chk(8'(sck_o), 8'(clock_polarity_select));
      rd(SPMS_IDX_DATA, 8'hA5 ^ 8'(m));
      chk(sv_rx, 8'h3C + 8'(m));
      slv_n <= 1'b1;
      $display("test mode %0d done", m);
    end
    wr(SPMS_IDX_CTL, 8'h04);
    wr(SPMS_IDX_CTL, 8'h34);
    ss_n <= 1'b0;
    repeat (6) @(posedge clk);
    ss_n <= 1'b1;
    rd(SPMS_IDX_STAT, 8'h10);
    rd(SPMS_IDX_CTL, 8'h04);
    chk(8'(mosi_oe | miso_oe | sck_oe), 8'h00);
    rd(SPMS_IDX_STAT, 8'h00);
    $display("test fault done");
    for (int m = 0; m < 4; m++) begin
      clock_polarity_select  <= m[1];
      clock_phase_select  <= m[0];
      m_sck <= m[1];
      wr(SPMS_IDX_CTL, 8'h20 | (8'(m) << 2));
      wr(SPMS_IDX_DATA, 8'h69 ^ 8'(m));
      ss_n <= 1'b0;
      xfer(8'h96 + 8'(m));
      chk(sl_rx, 8'h69 ^ 8'(m));
      ss_n <= 1'b1;
      rd(SPMS_IDX_STAT, 8'h80);
      rd(SPMS_IDX_DATA, 8'h96 + 8'(m));
      $display("test slave mode %0d done", m);
    end
    results();
  end
endmodule
